// *** core/hiefl_cmp.sv ***
// Threshold comparator: flags a fill or free count strictly above a programmed level.
module hiefl_cmp #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] count,
    input  wire logic [W-1:0] level,
    output logic              above
);
    assign above = count > level;
endmodule

// *** core/hiefl_pkg.sv ***
// Package with the register map, field layout and reset values of the host interrupt gating block.
// How it works
// - Enabled pending status bits drive the request output.
// - Status sources record regardless; software bit follows enable.
// - Enable bits share the status register layout.
// - Bits 31..29: software, ready, timestamp; reset zero.
// - Bits 28..26: switch engine, port2, port1 PHY.
// - Bits 25, 24: transmitter and receiver stopped.
// - Bits 23, 21, 20: drop-half, tx completion, rx DMA.
// - Bits 19, 17, 16: timer, power event, status overflow.
// - Bits 15..12: watchdog, rx error, tx error, GPIO.
// - Bits 10..7: overrun, space available, status full, level.
// - Bits 6, 4, 3: dropped frame, rx full, rx level.
// - Level bits 31:24: tx free blocks threshold, reset 48h.
// - Level bits 23:16: tx status words threshold, reset 00h.
// - Level bits 7:0: rx status words threshold, reset zero.
// - Space-available event when free space exceeds level.
package hiefl_pkg;
    localparam logic [7:0]  HIEFL_OFS_ENABLE   = 8'h5C;
    localparam logic [7:0]  HIEFL_OFS_LEVEL    = 8'h68;
    localparam logic [31:0] HIEFL_ENABLE_WMASK = 32'hFFBB_FFF8;
    localparam logic [31:0] HIEFL_ENABLE_RST   = 32'h0000_0000;
    localparam logic [31:0] HIEFL_LEVEL_RST    = 32'h4800_0000;
    localparam int          HIEFL_BIT_SW       = 31;
    localparam int          HIEFL_BIT_TXSPACE  = 9;
    localparam int          HIEFL_BIT_TXLEVEL  = 7;
    localparam int          HIEFL_BIT_RXLEVEL  = 3;
    localparam int          HIEFL_TXLVL_LSB    = 24;
    localparam int          HIEFL_TSLVL_LSB    = 16;
    localparam int          HIEFL_RSLVL_LSB    = 0;
    localparam int          HIEFL_LVL_W        = 8;

    typedef struct packed {
        logic [31:0] enable_r;
        logic [31:0] level_r;
        logic [31:0] rdata_r;
        logic        rvalid_r;
        logic        irq_r;
        logic        tx_space_r;
        logic        tx_stat_r;
        logic        rx_stat_r;
    } hiefl_state_t;
endpackage

// *** core/hiefl_top.sv ***
// Host interrupt enable and FIFO level threshold block with its register port.
module hiefl_top
    import hiefl_pkg::*;
#(
    parameter int CNT_W = HIEFL_LVL_W
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic [31:0]       interrupt_status,
    input  wire logic [CNT_W-1:0]  tx_free_blocks,
    input  wire logic [CNT_W-1:0]  tx_status_used,
    input  wire logic [CNT_W-1:0]  rx_status_used,
    output logic                   tx_space_available_event,
    output logic                   tx_status_level_event,
    output logic                   rx_status_level_event,
    output logic                   software_irq_enable,
    output logic                   irq
);
    logic         rst_meta_r;
    logic         rst_sync_n;
    hiefl_state_t st_r;
    hiefl_state_t st_nxt;
    logic         tx_above;
    logic         ts_above;
    logic         rs_above;

    // The release is synchronised so that no flop leaves reset on a different edge than its neighbours.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    hiefl_cmp #(.W(CNT_W)) u_cmp_tx (
        .count (tx_free_blocks),
        .level (st_r.level_r[HIEFL_TXLVL_LSB +: CNT_W]),
        .above (tx_above)
    );
    hiefl_cmp #(.W(CNT_W)) u_cmp_ts (
        .count (tx_status_used),
        .level (st_r.level_r[HIEFL_TSLVL_LSB +: CNT_W]),
        .above (ts_above)
    );
    hiefl_cmp #(.W(CNT_W)) u_cmp_rs (
        .count (rx_status_used),
        .level (st_r.level_r[HIEFL_RSLVL_LSB +: CNT_W]),
        .above (rs_above)
    );

    always_comb begin
        st_nxt = st_r;
        // Reserved writable bits are stored as written; keeping them zero is up to software.
        if (reg_wr) begin
            if (reg_addr == HIEFL_OFS_ENABLE) begin
                st_nxt.enable_r = reg_wdata & HIEFL_ENABLE_WMASK;
            end else if (reg_addr == HIEFL_OFS_LEVEL) begin
                st_nxt.level_r = reg_wdata;
            end
        end
        st_nxt.rvalid_r = reg_rd;
        if (reg_rd) begin
            if (reg_addr == HIEFL_OFS_ENABLE) begin
                st_nxt.rdata_r = st_r.enable_r;
            end else if (reg_addr == HIEFL_OFS_LEVEL) begin
                st_nxt.rdata_r = st_r.level_r;
            end else begin
                st_nxt.rdata_r = 32'h0000_0000;
            end
        end
        // One bitwise gate serves every source, so each enable sits at its status bit position.
        st_nxt.irq_r      = |(interrupt_status & st_r.enable_r);
        st_nxt.tx_space_r = tx_above;
        st_nxt.tx_stat_r  = ts_above;
        st_nxt.rx_stat_r  = rs_above;
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r <= '{enable_r: HIEFL_ENABLE_RST, level_r: HIEFL_LEVEL_RST, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata                = st_r.rdata_r;
    assign reg_rvalid               = st_r.rvalid_r;
    assign irq                      = st_r.irq_r;
    assign tx_space_available_event = st_r.tx_space_r;
    assign tx_status_level_event    = st_r.tx_stat_r;
    assign rx_status_level_event    = st_r.rx_stat_r;
    // The status register outside only latches a software request while this bit is set.
    assign software_irq_enable      = st_r.enable_r[HIEFL_BIT_SW];

    // Every output is registered, so the checks below that tie an output to its cause look one edge back for it.

    // Interrupt request gating.
    chk_irq_follows_pair: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        1'b1 |=> (irq == |($past(interrupt_status) & $past(st_r.enable_r))))
        else $error("irq does not follow enabled status");

    chk_irq_masked_low: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (st_r.enable_r == 32'h0000_0000) [*2] |-> !irq)
        else $error("irq high with all enables clear");

    chk_irq_drops: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (interrupt_status & st_r.enable_r) == 32'h0000_0000 |=> !irq)
        else $error("irq stays high with no enabled status");

    chk_irq_rise_cause: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        $rose(irq) |-> |($past(interrupt_status) & $past(st_r.enable_r)))
        else $error("irq rose without an enabled status");

    chk_irq_fall_cause: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        $fell(irq) |-> (|($past(interrupt_status) & $past(st_r.enable_r))) == 1'b0)
        else $error("irq fell while an enabled status remained");

    chk_sw_gate: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        interrupt_status[HIEFL_BIT_SW] && st_r.enable_r[HIEFL_BIT_SW] |=> irq)
        else $error("software source does not reach irq");

    chk_tx_space_gate: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        interrupt_status[HIEFL_BIT_TXSPACE] && st_r.enable_r[HIEFL_BIT_TXSPACE] |=> irq)
        else $error("tx space source does not reach irq");

    chk_tx_level_gate: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        interrupt_status[HIEFL_BIT_TXLEVEL] && st_r.enable_r[HIEFL_BIT_TXLEVEL] |=> irq)
        else $error("tx status level source does not reach irq");

    chk_rx_level_gate: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        interrupt_status[HIEFL_BIT_RXLEVEL] && st_r.enable_r[HIEFL_BIT_RXLEVEL] |=> irq)
        else $error("rx status level source does not reach irq");

    // Enable register and the exported software enable.
    chk_enable_write_mask: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        reg_wr && reg_addr == HIEFL_OFS_ENABLE |=> st_r.enable_r == ($past(reg_wdata) & HIEFL_ENABLE_WMASK))
        else $error("enable write not masked");

    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (st_r.enable_r & ~HIEFL_ENABLE_WMASK) == 32'h0000_0000)
        else $error("reserved enable bit set");

    chk_enable_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        !(reg_wr && reg_addr == HIEFL_OFS_ENABLE) |=> $stable(st_r.enable_r))
        else $error("enable register changed without a write");

    chk_sw_enable_out: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        reg_wr && reg_addr == HIEFL_OFS_ENABLE |=> software_irq_enable == $past(reg_wdata[HIEFL_BIT_SW]))
        else $error("software enable not shown");

    chk_sw_enable_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        !(reg_wr && reg_addr == HIEFL_OFS_ENABLE) |=> $stable(software_irq_enable))
        else $error("software enable changed without a write");

    // Reset values, seen at the first edge after the internal release.
    chk_reset_values: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        $rose(rst_sync_n) |-> st_r.enable_r == HIEFL_ENABLE_RST && st_r.level_r == HIEFL_LEVEL_RST)
        else $error("registers not at their reset values");

    chk_reset_outputs: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        $rose(rst_sync_n) |-> !irq && !reg_rvalid && !software_irq_enable && !tx_space_available_event)
        else $error("outputs not quiet after reset");

    // Level register and threshold events; a count equal to its level stays quiet.
    chk_level_write: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        reg_wr && reg_addr == HIEFL_OFS_LEVEL |=> st_r.level_r == $past(reg_wdata))
        else $error("level write lost");

    chk_level_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        !(reg_wr && reg_addr == HIEFL_OFS_LEVEL) |=> $stable(st_r.level_r))
        else $error("level register changed without a write");

    chk_tx_space_cmp: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        1'b1 |=> tx_space_available_event == ($past(tx_free_blocks) > $past(st_r.level_r[HIEFL_TXLVL_LSB +: CNT_W])))
        else $error("tx space event wrong");

    chk_tx_stat_cmp: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        1'b1 |=> tx_status_level_event == ($past(tx_status_used) > $past(st_r.level_r[HIEFL_TSLVL_LSB +: CNT_W])))
        else $error("tx status level event wrong");

    chk_rx_stat_cmp: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        1'b1 |=> rx_status_level_event == ($past(rx_status_used) > $past(st_r.level_r[HIEFL_RSLVL_LSB +: CNT_W])))
        else $error("rx status level event wrong");

    chk_tx_space_ceiling: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        &st_r.level_r[HIEFL_TXLVL_LSB +: CNT_W] |=> !tx_space_available_event)
        else $error("tx space event above the largest level");

    chk_tx_stat_ceiling: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        &st_r.level_r[HIEFL_TSLVL_LSB +: CNT_W] |=> !tx_status_level_event)
        else $error("tx status event above the largest level");

    chk_rx_stat_ceiling: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        &st_r.level_r[HIEFL_RSLVL_LSB +: CNT_W] |=> !rx_status_level_event)
        else $error("rx status event above the largest level");

    // Register read port.
    chk_read_enable: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        reg_rd && reg_addr == HIEFL_OFS_ENABLE |=> reg_rvalid && reg_rdata == $past(st_r.enable_r))
        else $error("enable readback wrong");

    chk_read_level: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        reg_rd && reg_addr == HIEFL_OFS_LEVEL |=> reg_rvalid && reg_rdata == $past(st_r.level_r))
        else $error("level readback wrong");

    chk_read_unmapped: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        reg_rd && reg_addr != HIEFL_OFS_ENABLE && reg_addr != HIEFL_OFS_LEVEL |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_rvalid_pulse: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        1'b1 |=> reg_rvalid == $past(reg_rd))
        else $error("read valid does not follow the read strobe");

    chk_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the host interrupt enable and FIFO level threshold block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hiefl_pkg::*;

    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] interrupt_status = 32'h0000_0000;
    logic [7:0]  tx_free_blocks = 8'h00;
    logic [7:0]  tx_status_used = 8'h00;
    logic [7:0]  rx_status_used = 8'h00;
    logic [31:0] reg_rdata;
    logic        reg_rvalid;
    logic        tx_space_available_event;
    logic        tx_status_level_event;
    logic        rx_status_level_event;
    logic        software_irq_enable;
    logic        irq;
    logic [31:0] exp_q[$];
    logic [31:0] en;
    logic [31:0] st;
    logic [31:0] lv;
    int          mismatches = 0;
    int          tests_run = 0;

    hiefl_top uut (.mclk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
                   .interrupt_status, .tx_free_blocks, .tx_status_used, .rx_status_used,
                   .tx_space_available_event, .tx_status_level_event, .rx_status_level_event,
                   .software_irq_enable, .irq);

    always #4 mclk = ~mclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // A gap cycle follows every strobe, so no strobe is driven twice in one time step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge mclk);
        reg_addr = a; reg_rd = 1'b1; exp_q.push_back(e);
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask

    // A read answer with no pending note is a stray pulse and counts as a mismatch.
    always @(negedge mclk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check(32'hFFFF_FFFF, 32'h0000_0000);
            else check(reg_rdata, exp_q.pop_front());
        end
    end

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #50000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        en = $urandom(32'hE4549DEE);
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        rd(8'h5C, 32'h0000_0000);
        rd(8'h68, 32'h4800_0000);
        rd(8'h60, 32'h0000_0000);
        wr(8'h5C, 32'hFFFF_F7DF);
        wr(8'h64, 32'hFFFF_FFFF);
        rd(8'h5C, 32'hFFBB_F7D8);
        rd(8'h68, 32'h4800_0000);
        $display("register reset and access test done");
        for (int i = 0; i < 32; i++) begin
            wr(8'h5C, (32'h1 << i) & 32'hFFFF_F7DF);
            interrupt_status = 32'h1 << i;
            @(negedge mclk);
            check(irq, 32'(32'hFFBB_F7D8 >> i) & 32'h1);
            interrupt_status = ~(32'h1 << i);
            @(negedge mclk);
            check(irq, 32'h0);
        end
        repeat (40) begin
            en = $urandom & 32'hFFBB_F7D8;
            st = $urandom;
            if ($urandom_range(1) == 0) st = st & ~en;
            wr(8'h5C, en);
            interrupt_status = st;
            @(negedge mclk);
            check(irq, {31'h0, |(st & en)});
            check(software_irq_enable, {31'h0, en[31]});
        end
        $display("interrupt gating test done");
        repeat (40) begin
            lv = $urandom & 32'hFFFF_00FF;
            wr(8'h68, lv);
            tx_free_blocks = lv[31:24] + 8'($urandom_range(2)) - 8'h01;
            tx_status_used = lv[23:16] + 8'($urandom_range(2)) - 8'h01;
            rx_status_used = lv[7:0] + 8'($urandom_range(2)) - 8'h01;
            @(negedge mclk);
            check(tx_space_available_event, {31'h0, tx_free_blocks > lv[31:24]});
            check(tx_status_level_event, {31'h0, tx_status_used > lv[23:16]});
            check(rx_status_level_event, {31'h0, rx_status_used > lv[7:0]});
            rd(8'h68, lv);
        end
        wr(8'h68, 32'hFFFF_00FF);
        tx_free_blocks = 8'hFF;
        tx_status_used = 8'hFF;
        rx_status_used = 8'hFF;
        @(negedge mclk);
        check(tx_space_available_event, 32'h0);
        check(tx_status_level_event, 32'h0);
        check(rx_status_level_event, 32'h0);
        $display("level threshold test done");
        wr(8'h5C, 32'h8000_0200);
        interrupt_status = 32'h8000_0200;
        @(negedge mclk);
        check(irq, 32'h1);
        check(software_irq_enable, 32'h1);
        rst_n = 1'b0;
        @(negedge mclk);
        check(irq, 32'h0);
        check(software_irq_enable, 32'h0);
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        rd(8'h5C, 32'h0000_0000);
        rd(8'h68, 32'h4800_0000);
        $display("mid-run reset test done");
        repeat (3) @(negedge mclk);
        check(32'(exp_q.size()), 32'h0000_0000);
        tally_and_finish();
    end
endmodule
